// File: inc/ocb_defines.vh
// Constants of the device configuration register bank
// Assumes byte offsets on an 8-bit register address, dword data
`ifndef OCB_DEFINES_VH
`define OCB_DEFINES_VH

// Byte offsets
`define OCB_OFF_SUMMARY      8'h80
`define OCB_OFF_SRC_LOW      8'h81
`define OCB_OFF_SRC_MID      8'h82
`define OCB_OFF_SRC_HIGH     8'h83
`define OCB_OFF_CD_CTRL      8'h84
`define OCB_OFF_CD_SPARE     8'h85
`define OCB_OFF_CD_LOW       8'h86
`define OCB_OFF_CD_HIGH      8'h87
`define OCB_OFF_SAMPLE       8'h88
`define OCB_OFF_SPARE_A      8'h89
`define OCB_OFF_CH_RESET     8'h8A
`define OCB_OFF_SLEEP        8'h8B
`define OCB_OFF_REVISION     8'h8C
`define OCB_OFF_PART_ID      8'h8D
`define OCB_OFF_SPARE_B      8'h8E
`define OCB_OFF_PIN_MASK     8'h8F
`define OCB_OFF_PIN_LEVEL    8'h90
`define OCB_OFF_PIN_OUT      8'h91
`define OCB_OFF_PIN_POL      8'h92
`define OCB_OFF_PIN_SEL      8'h93

// Dword indices, address bits 7:2
`define OCB_WORD_INT         6'h20
`define OCB_WORD_TIMER       6'h21
`define OCB_WORD_ANC1        6'h22
`define OCB_WORD_ANC2        6'h23
`define OCB_WORD_PIN         6'h24

// Reset values
`define OCB_RST_ZERO         8'h00
`define OCB_RST_PIN_SEL      8'hFF
`define OCB_RST_INT_WORD     32'h0000_0000

// Field positions
`define OCB_CODE_W           3
`define OCB_CODE_LSB         8
`define OCB_CD_INT_EN_BIT    0

// Source codes, lowest code wins
`define OCB_CODE_NONE        3'h0
`define OCB_CODE_RX          3'h1
`define OCB_CODE_RX_TO       3'h2
`define OCB_CODE_TX          3'h3
`define OCB_CODE_MODEM       3'h4
`define OCB_CODE_PIN         3'h6
`define OCB_CODE_TIMER       3'h7

`endif

// File: hw/ocb_src_encoder.v
// Per-channel priority encoder of pending service sources
// Assumes source requests are levels held by the channel logic
`timescale 1ns/1ps
`default_nettype none
`include "ocb_defines.vh"

module ocb_src_encoder #(
   parameter DEV_SRC = 0
) (
   input  wire       i_rx,
   input  wire       i_rx_to,
   input  wire       i_tx,
   input  wire       i_modem,
   input  wire       i_pin,
   input  wire       i_timer,
   output reg  [2:0] o_code
);

   always @* begin
      if (i_rx) begin
         o_code = `OCB_CODE_RX;
      end else if (i_rx_to) begin
         o_code = `OCB_CODE_RX_TO;
      end else if (i_tx) begin
         o_code = `OCB_CODE_TX;
      end else if (i_modem) begin
         o_code = `OCB_CODE_MODEM;
      end else if ((DEV_SRC != 0) && i_pin) begin
         o_code = `OCB_CODE_PIN;
      end else if ((DEV_SRC != 0) && i_timer) begin
         o_code = `OCB_CODE_TIMER;
      end else begin
         o_code = `OCB_CODE_NONE;
      end
   end

endmodule
`default_nettype wire

// File: hw/ocb_byte_reg.v
// One read/write configuration byte with its reset value
// Assumes a synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none

module ocb_byte_reg #(
   parameter [7:0] RESET_VAL = 8'h00
) (
   input  wire       i_clk,
   input  wire       i_reset_n,
   input  wire       i_wr,
   input  wire [7:0] i_wdata,
   output reg  [7:0] o_q
);

   always @(posedge i_clk) begin
      if (!i_reset_n) begin
         o_q <= RESET_VAL;
      end else if (i_wr) begin
         o_q <= i_wdata;
      end
   end

endmodule
`default_nettype wire

// File: hw/ocb_cfg_bank.v
// Device configuration register bank of the eight-channel serial controller
// Assumes a host register port with byte enables, one access per cycle
`timescale 1ns/1ps
`default_nettype none
`include "ocb_defines.vh"

module ocb_cfg_bank #(
   parameter [7:0] REVISION_VAL = 8'h01,
   parameter [7:0] PART_ID_VAL  = 8'h5A,
   parameter       CHANNELS     = 8
) (
   input  wire                I_REF_CLK,
   input  wire                I_RESETN,
   input  wire [7:0]          I_ADDR,
   input  wire [3:0]          I_BE,
   input  wire                I_WR,
   input  wire                I_RD,
   input  wire [31:0]         I_WDATA,
   input  wire [CHANNELS-1:0] I_RX_REQ,
   input  wire [CHANNELS-1:0] I_RX_TO_REQ,
   input  wire [CHANNELS-1:0] I_TX_REQ,
   input  wire [CHANNELS-1:0] I_MODEM_REQ,
   input  wire                I_TIMER_EXPIRE,
   input  wire                I_WAKE_EVT,
   input  wire [7:0]          I_PIN_IN,
   output reg  [31:0]         O_RDATA,
   output reg                 O_RVALID,
   output reg                 O_INT_PEND,
   output reg                 O_WAKE_PEND,
   output reg  [7:0]          O_CHAN_RESET,
   output reg  [7:0]          O_SAMPLE_8X,
   output reg  [7:0]          O_SLEEP_EN,
   output reg  [7:0]          O_CD_CTRL,
   output reg  [15:0]         O_CD_VALUE,
   output reg  [7:0]          O_PIN_LEVEL,
   output reg  [7:0]          O_PIN_OUT_CTRL,
   output reg  [7:0]          O_PIN_SEL
);

   // Word decode
   wire [5:0]   word_idx;
   wire         hit_int;
   wire         hit_timer;
   wire         hit_anc1;
   wire         hit_anc2;
   wire         hit_pin;

   assign word_idx  = I_ADDR[7:2];
   assign hit_int   = (word_idx == `OCB_WORD_INT);
   assign hit_timer = (word_idx == `OCB_WORD_TIMER);
   assign hit_anc1  = (word_idx == `OCB_WORD_ANC1);
   assign hit_anc2  = (word_idx == `OCB_WORD_ANC2);
   assign hit_pin   = (word_idx == `OCB_WORD_PIN);

   // Byte write strobes
   wire         wr_cd_ctrl;
   wire         wr_cd_low;
   wire         wr_cd_high;
   wire         wr_sample;
   wire         wr_ch_reset;
   wire         wr_sleep;
   wire         wr_pin_mask;
   wire         wr_pin_level;
   wire         wr_pin_out;
   wire         wr_pin_pol;
   wire         wr_pin_sel;

   assign wr_cd_ctrl   = I_WR && hit_timer && I_BE[0];
   assign wr_cd_low    = I_WR && hit_timer && I_BE[2];
   assign wr_cd_high   = I_WR && hit_timer && I_BE[3];
   assign wr_sample    = I_WR && hit_anc1 && I_BE[0];
   assign wr_ch_reset  = I_WR && hit_anc1 && I_BE[2];
   assign wr_sleep     = I_WR && hit_anc1 && I_BE[3];
   assign wr_pin_mask  = I_WR && hit_anc2 && I_BE[3];
   assign wr_pin_level = I_WR && hit_pin && I_BE[0];
   assign wr_pin_out   = I_WR && hit_pin && I_BE[1];
   assign wr_pin_pol   = I_WR && hit_pin && I_BE[2];
   assign wr_pin_sel   = I_WR && hit_pin && I_BE[3];

   // Read side-effect strobes
   wire         rd_summary;
   wire         rd_cd_ctrl;
   wire         rd_pin_level;

   assign rd_summary   = I_RD && hit_int && I_BE[0];
   assign rd_cd_ctrl   = I_RD && hit_timer && I_BE[0];
   assign rd_pin_level = I_RD && hit_pin && I_BE[0];

   // Read/write bytes
   wire [7:0]   cd_ctrl;
   wire [7:0]   cd_low;
   wire [7:0]   cd_high;
   wire [7:0]   sample_8x;
   wire [7:0]   sleep_en;
   wire [7:0]   pin_mask;
   wire [7:0]   pin_level;
   wire [7:0]   pin_out;
   wire [7:0]   pin_pol;
   wire [7:0]   pin_sel;

   ocb_byte_reg #(.RESET_VAL(`OCB_RST_ZERO)) u_cd_ctrl (
      .i_clk     (I_REF_CLK),
      .i_reset_n (I_RESETN),
      .i_wr      (wr_cd_ctrl),
      .i_wdata   (I_WDATA[7:0]),
      .o_q       (cd_ctrl)
   );

   ocb_byte_reg #(.RESET_VAL(`OCB_RST_ZERO)) u_cd_low (
      .i_clk     (I_REF_CLK),
      .i_reset_n (I_RESETN),
      .i_wr      (wr_cd_low),
      .i_wdata   (I_WDATA[23:16]),
      .o_q       (cd_low)
   );

   ocb_byte_reg #(.RESET_VAL(`OCB_RST_ZERO)) u_cd_high (
      .i_clk     (I_REF_CLK),
      .i_reset_n (I_RESETN),
      .i_wr      (wr_cd_high),
      .i_wdata   (I_WDATA[31:24]),
      .o_q       (cd_high)
   );

   ocb_byte_reg #(.RESET_VAL(`OCB_RST_ZERO)) u_sample (
      .i_clk     (I_REF_CLK),
      .i_reset_n (I_RESETN),
      .i_wr      (wr_sample),
      .i_wdata   (I_WDATA[7:0]),
      .o_q       (sample_8x)
   );

   ocb_byte_reg #(.RESET_VAL(`OCB_RST_ZERO)) u_sleep (
      .i_clk     (I_REF_CLK),
      .i_reset_n (I_RESETN),
      .i_wr      (wr_sleep),
      .i_wdata   (I_WDATA[31:24]),
      .o_q       (sleep_en)
   );

   ocb_byte_reg #(.RESET_VAL(`OCB_RST_ZERO)) u_pin_mask (
      .i_clk     (I_REF_CLK),
      .i_reset_n (I_RESETN),
      .i_wr      (wr_pin_mask),
      .i_wdata   (I_WDATA[31:24]),
      .o_q       (pin_mask)
   );

   ocb_byte_reg #(.RESET_VAL(`OCB_RST_ZERO)) u_pin_level (
      .i_clk     (I_REF_CLK),
      .i_reset_n (I_RESETN),
      .i_wr      (wr_pin_level),
      .i_wdata   (I_WDATA[7:0]),
      .o_q       (pin_level)
   );

   ocb_byte_reg #(.RESET_VAL(`OCB_RST_ZERO)) u_pin_out (
      .i_clk     (I_REF_CLK),
      .i_reset_n (I_RESETN),
      .i_wr      (wr_pin_out),
      .i_wdata   (I_WDATA[15:8]),
      .o_q       (pin_out)
   );

   ocb_byte_reg #(.RESET_VAL(`OCB_RST_ZERO)) u_pin_pol (
      .i_clk     (I_REF_CLK),
      .i_reset_n (I_RESETN),
      .i_wr      (wr_pin_pol),
      .i_wdata   (I_WDATA[23:16]),
      .o_q       (pin_pol)
   );

   ocb_byte_reg #(.RESET_VAL(`OCB_RST_PIN_SEL)) u_pin_sel (
      .i_clk     (I_REF_CLK),
      .i_reset_n (I_RESETN),
      .i_wr      (wr_pin_sel),
      .i_wdata   (I_WDATA[31:24]),
      .o_q       (pin_sel)
   );

   // Device-wide event flags
   reg          timer_flag_q;
   reg          pin_flag_q;
   reg          wake_flag_q;
   reg  [7:0]   pin_act_q;
   wire [7:0]   pin_act;
   wire         pin_rise;

   // Polarity-corrected, masked inputs on input-selected pins
   assign pin_act  = (I_PIN_IN ^ pin_pol) & pin_mask & pin_sel;
   assign pin_rise = |(pin_act & ~pin_act_q);

   always @(posedge I_REF_CLK) begin
      if (!I_RESETN) begin
         timer_flag_q <= 1'b0;
         pin_flag_q   <= 1'b0;
         wake_flag_q  <= 1'b0;
         pin_act_q    <= `OCB_RST_ZERO;
      end else begin
         pin_act_q <= pin_act;
         if (I_TIMER_EXPIRE && cd_ctrl[`OCB_CD_INT_EN_BIT]) begin
            timer_flag_q <= 1'b1;
         end else if (rd_cd_ctrl) begin
            timer_flag_q <= 1'b0;
         end
         if (pin_rise) begin
            pin_flag_q <= 1'b1;
         end else if (rd_pin_level) begin
            pin_flag_q <= 1'b0;
         end
         if (I_WAKE_EVT) begin
            wake_flag_q <= 1'b1;
         end else if (rd_summary) begin
            wake_flag_q <= 1'b0;
         end
      end
   end

   // Per-channel encoding
   wire [CHANNELS-1:0]   chan_req;
   wire [3*CHANNELS-1:0] code_d;

   genvar k;
   generate
      for (k = 0; k < CHANNELS; k = k + 1) begin : g_chan
         assign chan_req[k] = I_RX_REQ[k] | I_RX_TO_REQ[k] | I_TX_REQ[k] | I_MODEM_REQ[k] |
                              ((k == 0) ? (timer_flag_q | pin_flag_q) : 1'b0);
         // device sources only in channel 0
         ocb_src_encoder #(.DEV_SRC((k == 0) ? 1 : 0)) u_enc (
            .i_rx    (I_RX_REQ[k]),
            .i_rx_to (I_RX_TO_REQ[k]),
            .i_tx    (I_TX_REQ[k]),
            .i_modem (I_MODEM_REQ[k]),
            .i_pin   ((k == 0) ? pin_flag_q : 1'b0),
            .i_timer ((k == 0) ? timer_flag_q : 1'b0),
            .o_code  (code_d[3*k+2:3*k])
         );
      end
   endgenerate

   reg  [31:0]  int_word_q;

   always @(posedge I_REF_CLK) begin
      if (!I_RESETN) begin
         int_word_q <= `OCB_RST_INT_WORD;
      end else begin
         int_word_q[7:0]  <= chan_req;
         int_word_q[31:`OCB_CODE_LSB] <= code_d;
      end
   end

   // Read data
   reg  [31:0]  rword;
   wire [31:0]  lane_mask;

   assign lane_mask = {{8{I_BE[3]}}, {8{I_BE[2]}}, {8{I_BE[1]}}, {8{I_BE[0]}}};

   always @* begin
      case (word_idx)
         // whole word from one flop set
         `OCB_WORD_INT: begin
            rword = int_word_q;
         end
         `OCB_WORD_TIMER: begin
            rword = {cd_high, cd_low, `OCB_RST_ZERO, cd_ctrl};
         end
         `OCB_WORD_ANC1: begin
            rword = {sleep_en, `OCB_RST_ZERO, `OCB_RST_ZERO, sample_8x};
         end
         `OCB_WORD_ANC2: begin
            rword = {pin_mask, `OCB_RST_ZERO, PART_ID_VAL, REVISION_VAL};
         end
         `OCB_WORD_PIN: begin
            rword = {pin_sel, pin_pol, pin_out, pin_level};
         end
         default: begin
            rword = 32'h0000_0000;
         end
      endcase
   end

   always @(posedge I_REF_CLK) begin
      if (!I_RESETN) begin
         O_RDATA  <= 32'h0000_0000;
         O_RVALID <= 1'b0;
      end else begin
         O_RVALID <= I_RD;
         if (I_RD) begin
            O_RDATA <= rword & lane_mask;
         end
      end
   end

   // Output flops
   always @(posedge I_REF_CLK) begin
      if (!I_RESETN) begin
         O_INT_PEND     <= 1'b0;
         O_WAKE_PEND    <= 1'b0;
         O_CHAN_RESET   <= `OCB_RST_ZERO;
         O_SAMPLE_8X    <= `OCB_RST_ZERO;
         O_SLEEP_EN     <= `OCB_RST_ZERO;
         O_CD_CTRL      <= `OCB_RST_ZERO;
         O_CD_VALUE     <= {`OCB_RST_ZERO, `OCB_RST_ZERO};
         O_PIN_LEVEL    <= `OCB_RST_ZERO;
         O_PIN_OUT_CTRL <= `OCB_RST_ZERO;
         O_PIN_SEL      <= `OCB_RST_PIN_SEL;
      end else begin
         O_INT_PEND     <= (|int_word_q[7:0]) | wake_flag_q;
         O_WAKE_PEND    <= wake_flag_q;
         O_CHAN_RESET   <= wr_ch_reset ? I_WDATA[23:16] : `OCB_RST_ZERO;
         O_SAMPLE_8X    <= sample_8x;
         O_SLEEP_EN     <= sleep_en;
         O_CD_CTRL      <= cd_ctrl;
         O_CD_VALUE     <= {cd_high, cd_low};
         O_PIN_LEVEL    <= pin_level;
         O_PIN_OUT_CTRL <= pin_out;
         O_PIN_SEL      <= pin_sel;
      end
   end

endmodule
`default_nettype wire

// File: sim/ocb_cfg_bank_assertions.sv
// Port checker of the configuration register bank
// Assumes binding to ocb_cfg_bank, one clock domain
`timescale 1ns/1ps
`default_nettype none
module ocb_cfg_bank_chk #(
   parameter CHANNELS = 8
) (
   input wire logic                I_REF_CLK,
   input wire logic                I_RESETN,
   input wire logic [7:0]          I_ADDR,
   input wire logic [3:0]          I_BE,
   input wire logic                I_WR,
   input wire logic                I_RD,
   input wire logic [31:0]         I_WDATA,
   input wire logic [CHANNELS-1:0] I_RX_REQ,
   input wire logic                I_WAKE_EVT,
   input wire logic [31:0]         O_RDATA,
   input wire logic                O_RVALID,
   input wire logic                O_INT_PEND,
   input wire logic                O_WAKE_PEND,
   input wire logic [7:0]          O_CHAN_RESET
);
   logic code_bad;
   always_comb begin
      code_bad = 1'b0;
      for (int k = 1; k < 8; k++) begin
         code_bad = code_bad | (O_RDATA[9+3*k] & O_RDATA[10+3*k]);
      end
   end
   default clocking cb @(posedge I_REF_CLK); endclocking
   default disable iff (!I_RESETN);
   chk_read_answer: assert property (
      O_RVALID == $past(I_RD)) else $error("read answer missing or spurious");
   chk_rdata_hold: assert property (
      !I_RD |=> $stable(O_RDATA)) else $error("read data moved without a read");
   chk_chan_reset_pulse: assert property (
      I_WR && I_ADDR[7:2] == 6'h22 && I_BE[2] |=> O_CHAN_RESET == $past(I_WDATA[23:16]))
      else $error("channel reset pulse wrong");
   chk_chan_reset_clear: assert property (
      O_CHAN_RESET != 8'h00 && !I_WR |=> O_CHAN_RESET == 8'h00) else $error("channel reset not self clearing");
   chk_wake_set: assert property (
      I_WAKE_EVT |-> ##[1:2] O_WAKE_PEND) else $error("wake condition not raised");
   chk_wake_clear: assert property (
      O_WAKE_PEND && I_RD && I_ADDR[7:2] == 6'h20 && I_BE[0] && !I_WAKE_EVT ##1 !I_WAKE_EVT |=> !O_WAKE_PEND)
      else $error("wake condition not cleared");
   chk_int_pend_src: assert property (
      (I_RX_REQ != '0) [*3] |-> O_INT_PEND) else $error("pending source not flagged");
   chk_lane_zero: assert property (
      I_RD && !I_BE[0] |=> O_RDATA[7:0] == 8'h00) else $error("disabled lane not zero");
   chk_wo_read_zero: assert property (
      I_RD && I_ADDR[7:2] == 6'h22 |=> O_RDATA[23:8] == 16'h0000) else $error("write-only byte readable");
   chk_unmapped_zero: assert property (
      I_RD && (I_ADDR[7:2] < 6'h20 || I_ADDR[7:2] > 6'h24) |=> O_RDATA == 32'h0000_0000)
      else $error("unmapped read not zero");
   chk_code_ch0_only: assert property (
      I_RD && I_ADDR[7:2] == 6'h20 |=> !code_bad) else $error("device code outside channel 0");
endmodule
`default_nettype wire

// File: sim/ocb_host_model.sv
// Host master model of the register port
// Assumes one access at a time, answer within four cycles
`timescale 1ns/1ps
`default_nettype none
module ocb_host_model (
   input  wire logic        i_clk,
   input  wire logic [31:0] i_rdata,
   input  wire logic        i_rvalid,
   output var  logic [7:0]  o_addr,
   output var  logic [3:0]  o_be,
   output var  logic        o_wr,
   output var  logic        o_rd,
   output var  logic [31:0] o_wdata
);
   initial begin
      o_addr = 8'h00;
      o_be = 4'h0;
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_wdata = 32'h0000_0000;
   end
   task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
      @(posedge i_clk);
      o_addr <= a;
      o_be <= b;
      o_wdata <= d;
      o_wr <= 1'b1;
      @(posedge i_clk);
      o_wr <= 1'b0;
      o_wdata <= ~d;
   endtask
   task automatic rd(input logic [7:0] a, input logic [3:0] b, output logic [31:0] d, output bit ok);
      int n;
      @(posedge i_clk);
      o_addr <= a;
      o_be <= b;
      o_rd <= 1'b1;
      @(posedge i_clk);
      o_rd <= 1'b0;
      #1;
      n = 0;
      while (i_rvalid !== 1'b1 && n < 4) begin
         @(posedge i_clk);
         #1;
         n++;
      end
      ok = (i_rvalid === 1'b1);
      d = i_rdata;
   endtask
endmodule
`default_nettype wire

// File: sim/tb_top.sv
// Self-checking bench of the configuration register bank
// Assumes the host model drives the register port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam [7:0] REV = 8'h3C; // arbitrary value
   localparam [7:0] PID = 8'hC5; // arbitrary value
   logic        clk, rstn, timer, wake, wr, rd, rvalid, int_pend, wake_pend;
   logic [7:0]  rx, rx_to, tx, modem, pin_in, addr, chan_rst, smp, slp, cdc, plvl, pout, psel;
   logic [3:0]  be;
   logic [15:0] cdv;
   logic [31:0] wdata, rdata, exp_w;
   logic [7:0]  v_rx, v_to, v_tx, v_md;
   logic [31:0] rst_exp [5];
   logic [31:0] wr_dat [5];
   logic [31:0] wr_exp [5];
   int          num_errors, samples_checked, lv;
   ocb_cfg_bank #(.REVISION_VAL(REV), .PART_ID_VAL(PID), .CHANNELS(8)) u_ocb_cfg_bank (
      .I_REF_CLK(clk), .I_RESETN(rstn), .I_ADDR(addr), .I_BE(be), .I_WR(wr), .I_RD(rd), .I_WDATA(wdata),
      .I_RX_REQ(rx), .I_RX_TO_REQ(rx_to), .I_TX_REQ(tx), .I_MODEM_REQ(modem), .I_TIMER_EXPIRE(timer),
      .I_WAKE_EVT(wake), .I_PIN_IN(pin_in), .O_RDATA(rdata), .O_RVALID(rvalid), .O_INT_PEND(int_pend),
      .O_WAKE_PEND(wake_pend), .O_CHAN_RESET(chan_rst), .O_SAMPLE_8X(smp), .O_SLEEP_EN(slp), .O_CD_CTRL(cdc),
      .O_CD_VALUE(cdv), .O_PIN_LEVEL(plvl), .O_PIN_OUT_CTRL(pout), .O_PIN_SEL(psel));
   ocb_host_model u_ocb_host_model (.i_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_addr(addr),
      .o_be(be), .o_wr(wr), .o_rd(rd), .o_wdata(wdata));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task report_and_stop;
      $display("compares %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         $display("mismatch %s expected %h seen %h", nm, e, g);
         num_errors++;
      end
   endtask
   task automatic rchk(input string nm, input logic [7:0] a, input logic [3:0] b, input logic [31:0] e);
      logic [31:0] d;
      bit          ok;
      u_ocb_host_model.rd(a, b, d, ok);
      if (!ok) begin
         num_errors++;
         $display("mismatch %s expected answer seen timeout", nm);
         report_and_stop;
      end
      check(nm, e, d);
   endtask
   task automatic reset_and_check;
      @(posedge clk);
      rstn <= 1'b0;
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         rchk("reset word", 8'(8'h80 + 4 * i), 4'hF, rst_exp[i]);
      end
      check("select out", 32'h0000_00FF, {24'h0, psel});
   endtask
   initial begin
      #1_000_000;
      num_errors++;
      $display("mismatch watchdog expected finish seen hang");
      report_and_stop;
   end
   initial begin
      {rstn, timer, wake, rx, rx_to, tx, modem, pin_in} = '0;
      num_errors = 0;
      samples_checked = 0;
      rst_exp = '{32'h0, 32'h0, 32'h0, {16'h0, PID, REV}, 32'hFF00_0000};
      wr_dat = '{32'hFFFF_FFFF, 32'hA5A5_A5A5, 32'h5A5A_5A5A, 32'h81FF_FFFF, 32'h1234_5678};
      wr_exp = '{32'h0, 32'hA5A5_00A5, 32'h5A00_005A, {16'h8100, PID, REV}, 32'h1234_5678};
      reset_and_check;
      rchk("unmapped", 8'h94, 4'hF, 32'h0000_0000);
      for (int i = 0; i < 5; i++) begin
         u_ocb_host_model.wr(8'(8'h80 + 4 * i), 4'hF, wr_dat[i]);
         rchk("word back", 8'(8'h80 + 4 * i), 4'hF, wr_exp[i]);
      end
      check("copies", 32'hA55A_5A78, {cdc, smp, slp, plvl});
      check("copies hi", 32'hA5A5_5612, {cdv, pout, psel});
      rchk("byte lane", 8'h91, 4'h2, 32'h0000_5600);
      for (int s = 0; s < 5; s++) begin
         exp_w = 32'h0;
         for (int k = 0; k < 8; k++) begin
            lv = (k + s) % 5;
            {v_rx[k], v_to[k], v_tx[k], v_md[k]} = {lv <= 0, lv <= 1, lv <= 2, lv <= 3};
            exp_w[k] = (lv < 4);
            exp_w[8+3*k+:3] = (lv < 4) ? 3'(lv + 1) : 3'h0;
         end
         @(posedge clk);
         {rx, rx_to, tx, modem} <= {v_rx, v_to, v_tx, v_md};
         repeat (3) @(posedge clk);
         rchk("source word", 8'h80, 4'hF, exp_w);
         rchk("source again", 8'h80, 4'hF, exp_w);
      end
      @(posedge clk) {rx, rx_to, tx, modem} <= '0;
      u_ocb_host_model.wr(8'h84, 4'h1, 32'h0);
      @(posedge clk) timer <= 1'b1;
      @(posedge clk) timer <= 1'b0;
      rchk("timer off", 8'h80, 4'hF, 32'h0000_0000);
      u_ocb_host_model.wr(8'h84, 4'h1, 32'h1);
      @(posedge clk) timer <= 1'b1;
      @(posedge clk) timer <= 1'b0;
      rchk("timer code", 8'h80, 4'hF, 32'h0000_0701);
      u_ocb_host_model.wr(8'h8C, 4'h8, 32'h0100_0000);
      u_ocb_host_model.wr(8'h90, 4'hC, 32'h0100_0000);
      @(posedge clk) pin_in <= 8'h01;
      repeat (3) @(posedge clk);
      rchk("pin code", 8'h80, 4'hF, 32'h0000_0601);
      rchk("pin level", 8'h90, 4'h1, 32'h0000_0078);
      rchk("pin cleared", 8'h80, 4'hF, 32'h0000_0701);
      rchk("timer ctrl", 8'h84, 4'h1, 32'h0000_0001);
      rchk("all clear", 8'h80, 4'hF, 32'h0000_0000);
      @(posedge clk) wake <= 1'b1;
      @(posedge clk) wake <= 1'b0;
      repeat (2) @(posedge clk);
      check("wake pend", 32'h1, {31'h0, wake_pend});
      check("int pend wake", 32'h1, {31'h0, int_pend});
      rchk("wake read", 8'h80, 4'h1, 32'h0000_0000);
      repeat (2) @(posedge clk);
      #1;
      check("wake clear", 32'h0, {31'h0, wake_pend});
      check("int pend clear", 32'h0, {31'h0, int_pend});
      reset_and_check;
      report_and_stop;
   end
endmodule
bind ocb_cfg_bank ocb_cfg_bank_chk #(.CHANNELS(CHANNELS)) u_ocb_cfg_bank_chk (.I_REF_CLK, .I_RESETN,
   .I_ADDR, .I_BE, .I_WR, .I_RD, .I_WDATA, .I_RX_REQ, .I_WAKE_EVT, .O_RDATA, .O_RVALID, .O_INT_PEND,
   .O_WAKE_PEND, .O_CHAN_RESET);
`default_nettype wire
